// File: logic/rss_params.svh
// Constants of the receiver status and event strobe block
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

`define RSS_NUM_CH         4
`define RSS_HP_W           24
`define RSS_CLK_PERIOD_NS  10
`define RSS_CLK_MHZ        (1000 / `RSS_CLK_PERIOD_NS)
// Mark pulse must be longer than this time
`define RSS_MARK_MIN_NS    150
`define RSS_MARK_MIN_CYC   ((`RSS_MARK_MIN_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
// Fastest event output, and its half period in cycles
`define RSS_FREQ_MAX_MHZ   50
`define RSS_HALF_MIN_CYC   ((`RSS_CLK_MHZ + 2 * `RSS_FREQ_MAX_MHZ - 1) / (2 * `RSS_FREQ_MAX_MHZ))
// Polarity resets: zero means active low
`define RSS_MARK_POL_RST   4'h0
`define RSS_FREQ_POL_RST   1'h0
`define RSS_HP_RST         24'h000001

`endif

// File: logic/rss_pkg.sv
// Types of the receiver status and event strobe block
`include "rss_params.svh"

package rss_pkg;

    typedef enum logic [4:0] {
        st_boot      = 5'h01,
        st_run       = 5'h02,
        st_recov     = 5'h04,
        st_fatal     = 5'h08,
        st_resetting = 5'h10
    } rss_state_type;

    typedef struct packed {
        logic boot_done;
        logic reset_busy;
        logic recov_error;
        logic fatal_error;
        logic restart_done;
        logic solution_ok;
    } rss_rx_cond_type;

    typedef struct packed {
        logic error;
        logic ready;
        logic pos_valid;
    } rss_flags_type;

    typedef struct packed {
        logic                       valid;
        logic [`RSS_NUM_CH-1:0]     active_high;
    } rss_mark_cfg_type;

    typedef struct packed {
        logic                       valid;
        logic [1:0]                 chan;
        logic                       enable;
        logic                       active_high;
        logic [`RSS_HP_W-1:0]       half_period;
    } rss_freq_cfg_type;

endpackage

// File: logic/rss_mark_qual.sv
// Event mark input qualifier: synchroniser, width counter, edge report
`timescale 1ns/1ns
`include "rss_params.svh"

module rss_mark_qual #(
    parameter int MIN_CYC = `RSS_MARK_MIN_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic mark_in,
    input  wire logic active_high,
    output logic      event_pulse
);

    localparam int CW = $clog2(MIN_CYC + 2);

    if (MIN_CYC < 1) begin : g_chk
        $error("rss_mark_qual: MIN_CYC must be at least 1");
    end

    logic          sync1_r;
    logic          sync2_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          event_r;
    logic          event_nxt;
    logic          active;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        active    = active_high ? sync2_r : ~sync2_r;
        cnt_nxt   = cnt_r;
        event_nxt = 1'b0;
        if (!active) begin
            cnt_nxt = '0;
        end else if (cnt_r <= CW'(MIN_CYC)) begin
            cnt_nxt = cnt_r + CW'(1);
            // Fires once the level has held longer than the minimum
            event_nxt = (cnt_r == CW'(MIN_CYC));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input is asynchronous; only the second stage is looked at
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Rest at the idle level of the default active-low pin, so no count starts after reset
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            cnt_r   <= '0;
            event_r <= 1'b0;
        end else begin
            sync1_r <= mark_in;
            sync2_r <= sync1_r;
            cnt_r   <= cnt_nxt;
            event_r <= event_nxt;
        end
    end

    assign event_pulse = event_r;

endmodule

// File: logic/rss_status_strobes.sv
// Receiver status flags, event mark inputs and event frequency outputs
//
// Functional notes
// - Error flag low in normal operation, high only while receiver is in a recoverable error.
// - Mark event registered only for pulses longer than 150 ns.
// - Mark polarity defaults to active low, selectable by configuration command.
// - Four event outputs, active low by default, programmable frequency up to 50 MHz.
// - Ready flag high means commands are being accepted.
// - Ready flag stays low during boot and while reset is in progress.
// - Recoverable error raises error flag while ready stays asserted.
// - Position-valid drops in the same cycle the error flag rises.
// - Fatal error clears ready, error and position-valid until restart completes.
// - Position-valid high only while a valid solution exists.
`timescale 1ns/1ns
`include "rss_params.svh"

module rss_status_strobes #(
    parameter int HP_W    = `RSS_HP_W,
    parameter int MIN_CYC = `RSS_MARK_MIN_CYC
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire rss_pkg::rss_rx_cond_type  rx_cond,
    input  wire logic                      mark_input_one,
    input  wire logic                      mark_input_two,
    input  wire logic                      mark_input_three,
    input  wire logic                      mark_input_four,
    input  wire rss_pkg::rss_mark_cfg_type mark_input_config_cmd,
    input  wire rss_pkg::rss_freq_cfg_type freq_output_config_cmd,
    output logic                           error_flag,
    output logic                           command_ready_flag,
    output logic                           position_valid_flag,
    output logic [`RSS_NUM_CH-1:0]         mark_event,
    output logic                           freq_output_one,
    output logic                           freq_output_two,
    output logic                           freq_output_three,
    output logic                           freq_output_four
);

    localparam int NCH = `RSS_NUM_CH;

    if (HP_W < 1 || HP_W > `RSS_HP_W) begin : g_chk_hp
        $error("rss_status_strobes: HP_W out of range");
    end
    if (MIN_CYC < 1) begin : g_chk_min
        $error("rss_status_strobes: MIN_CYC must be at least 1");
    end

    // Flag pattern shown in each receiver state
    function automatic rss_pkg::rss_flags_type flags_of(input rss_pkg::rss_state_type st,
                                                        input logic solution_ok);
        rss_pkg::rss_flags_type f;
        f = '0;
        case (st)
            rss_pkg::st_run: begin
                f.ready     = 1'b1;
                f.pos_valid = solution_ok;
            end
            rss_pkg::st_recov: begin
                f.error = 1'b1;
                f.ready = 1'b1;
                // Position-valid forced low with the error
            end
            default: begin
                f = '0;
            end
        endcase
        return f;
    endfunction

    // Pin level of one event output
    function automatic logic pin_level(input logic en, input logic pol, input logic phase);
        return en ? (pol ? phase : ~phase) : ~pol;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Receiver state and status flags
    rss_pkg::rss_state_type state_r;
    rss_pkg::rss_state_type state_nxt;
    rss_pkg::rss_flags_type flags_r;
    rss_pkg::rss_flags_type flags_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rss_pkg::st_boot: begin
                if (rx_cond.fatal_error) begin
                    state_nxt = rss_pkg::st_fatal;
                end else if (rx_cond.boot_done && !rx_cond.reset_busy) begin
                    state_nxt = rss_pkg::st_run;
                end
            end
            rss_pkg::st_run: begin
                if (rx_cond.fatal_error) begin
                    state_nxt = rss_pkg::st_fatal;
                end else if (rx_cond.reset_busy) begin
                    state_nxt = rss_pkg::st_resetting;
                end else if (rx_cond.recov_error) begin
                    state_nxt = rss_pkg::st_recov;
                end
            end
            rss_pkg::st_recov: begin
                if (rx_cond.fatal_error) begin
                    state_nxt = rss_pkg::st_fatal;
                end else if (rx_cond.reset_busy) begin
                    state_nxt = rss_pkg::st_resetting;
                end else if (!rx_cond.recov_error) begin
                    state_nxt = rss_pkg::st_run;
                end
            end
            rss_pkg::st_fatal: begin
                // Reboot: flags stay down until the restart is reported done
                if (rx_cond.restart_done) begin
                    state_nxt = rss_pkg::st_boot;
                end
            end
            rss_pkg::st_resetting: begin
                if (!rx_cond.reset_busy) begin
                    state_nxt = rss_pkg::st_boot;
                end
            end
            default: begin
                state_nxt = rss_pkg::st_boot;
            end
        endcase
        // Flags follow the next state so error and position-valid switch together
        flags_nxt = flags_of(state_nxt, rx_cond.solution_ok);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= rss_pkg::st_boot;
            flags_r <= '0;
        end else begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
        end
    end

    assign error_flag          = flags_r.error;
    assign command_ready_flag  = flags_r.ready;
    assign position_valid_flag = flags_r.pos_valid;

    ////////////////////////////////////////////////////////////////////////
    // Event mark inputs
    logic [NCH-1:0] mark_pol_r;
    logic [NCH-1:0] mark_pol_nxt;
    logic [NCH-1:0] mark_pins;

    assign mark_pins = {mark_input_four, mark_input_three, mark_input_two, mark_input_one};

    always_comb begin
        mark_pol_nxt = mark_pol_r;
        if (mark_input_config_cmd.valid) begin
            mark_pol_nxt = mark_input_config_cmd.active_high;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mark_pol_r <= `RSS_MARK_POL_RST;
        end else begin
            mark_pol_r <= mark_pol_nxt;
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_mark
        rss_mark_qual #(
            .MIN_CYC     (MIN_CYC)
        ) u_qual (
            .core_clk    (core_clk),
            .rst_n       (rst_n),
            .mark_in     (mark_pins[i]),
            .active_high (mark_pol_r[i]),
            .event_pulse (mark_event[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Event frequency outputs: divider tick toggles the phase
    logic [NCH-1:0]  fo_en_r;
    logic [NCH-1:0]  fo_en_nxt;
    logic [NCH-1:0]  fo_pol_r;
    logic [NCH-1:0]  fo_pol_nxt;
    logic [NCH-1:0]  fo_phase_r;
    logic [NCH-1:0]  fo_phase_nxt;
    logic [NCH-1:0]  fo_out_r;
    logic [NCH-1:0]  fo_out_nxt;
    logic [HP_W-1:0] fo_hp_r [NCH];
    logic [HP_W-1:0] fo_hp_nxt [NCH];
    logic [HP_W-1:0] fo_cnt_r [NCH];
    logic [HP_W-1:0] fo_cnt_nxt [NCH];

    always_comb begin
        fo_en_nxt    = fo_en_r;
        fo_pol_nxt   = fo_pol_r;
        fo_phase_nxt = fo_phase_r;
        for (int i = 0; i < NCH; i++) begin
            fo_hp_nxt[i]  = fo_hp_r[i];
            fo_cnt_nxt[i] = fo_cnt_r[i];
            if (freq_output_config_cmd.valid && freq_output_config_cmd.chan == 2'(i)) begin
                fo_en_nxt[i]    = freq_output_config_cmd.enable;
                fo_pol_nxt[i]   = freq_output_config_cmd.active_high;
                // Below the minimum half period would exceed the top frequency
                if (freq_output_config_cmd.half_period[HP_W-1:0] < HP_W'(`RSS_HALF_MIN_CYC)) begin
                    fo_hp_nxt[i] = HP_W'(`RSS_HALF_MIN_CYC);
                end else begin
                    fo_hp_nxt[i] = freq_output_config_cmd.half_period[HP_W-1:0];
                end
                fo_cnt_nxt[i]   = '0;
                fo_phase_nxt[i] = 1'b0;
            end else if (fo_en_r[i]) begin
                if (fo_cnt_r[i] >= fo_hp_r[i] - HP_W'(1)) begin
                    fo_cnt_nxt[i]   = '0;
                    fo_phase_nxt[i] = ~fo_phase_r[i];
                end else begin
                    fo_cnt_nxt[i] = fo_cnt_r[i] + HP_W'(1);
                end
            end
            fo_out_nxt[i] = pin_level(fo_en_nxt[i], fo_pol_nxt[i], fo_phase_nxt[i]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fo_en_r    <= '0;
            fo_pol_r   <= {NCH{`RSS_FREQ_POL_RST}};
            fo_phase_r <= '0;
            fo_out_r   <= ~{NCH{`RSS_FREQ_POL_RST}};
            for (int i = 0; i < NCH; i++) begin
                fo_hp_r[i]  <= HP_W'(`RSS_HP_RST);
                fo_cnt_r[i] <= '0;
            end
        end else begin
            fo_en_r    <= fo_en_nxt;
            fo_pol_r   <= fo_pol_nxt;
            fo_phase_r <= fo_phase_nxt;
            fo_out_r   <= fo_out_nxt;
            for (int i = 0; i < NCH; i++) begin
                fo_hp_r[i]  <= fo_hp_nxt[i];
                fo_cnt_r[i] <= fo_cnt_nxt[i];
            end
        end
    end

    assign freq_output_one   = fo_out_r[0];
    assign freq_output_two   = fo_out_r[1];
    assign freq_output_three = fo_out_r[2];
    assign freq_output_four  = fo_out_r[3];

endmodule

// File: tb/rss_status_strobes_asserts.sv
// Port-level assertion checker for the status and strobe block
`timescale 1ns/1ns
`include "rss_params.svh"
module rss_ss_chk #(
    parameter int HP_W    = 24,
    parameter int MIN_CYC = 15
) (
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    input wire rss_pkg::rss_rx_cond_type  rx_cond,
    input wire rss_pkg::rss_freq_cfg_type freq_output_config_cmd,
    input wire logic                      error_flag,
    input wire logic                      command_ready_flag,
    input wire logic                      position_valid_flag,
    input wire logic [`RSS_NUM_CH-1:0]    mark_event,
    input wire logic                      freq_output_one,
    input wire logic                      freq_output_two,
    input wire logic                      freq_output_three,
    input wire logic                      freq_output_four
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] flg;
    logic [3:0] fo;
    logic [3:0] fen_r;
    logic [3:0] fpol_r;
    assign flg = {error_flag, command_ready_flag, position_valid_flag};
    assign fo  = {freq_output_four, freq_output_three, freq_output_two, freq_output_one};
////////////////////////////////////////////////////////////
    // Shadow of the enable and polarity each channel was last given
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fen_r  <= 4'h0;
            fpol_r <= 4'h0;
        end else if (freq_output_config_cmd.valid) begin
            fen_r[freq_output_config_cmd.chan]  <= freq_output_config_cmd.enable;
            fpol_r[freq_output_config_cmd.chan] <= freq_output_config_cmd.active_high;
        end
    end
    sequence s_run;
        command_ready_flag && !error_flag;
    endsequence
    sequence s_calm;
        !rx_cond.fatal_error && !rx_cond.reset_busy;
    endsequence
////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property (!$past(rst_n) |-> flg == 3'h0 && fo == 4'hf && mark_event == 4'h0)
        else $error("outputs active after reset");
    chk_err_ready: assert property (error_flag |-> command_ready_flag) else $error("error without ready");
    chk_err_pos: assert property (error_flag |-> !position_valid_flag)
        else $error("position valid in error");
    chk_pos_run: assert property (position_valid_flag |-> s_run) else $error("position valid off run");
    chk_fatal_clear: assert property (rx_cond.fatal_error |=> flg == 3'h0) else $error("flags after fatal");
    chk_ready_hold: assert property (!command_ready_flag && (rx_cond.reset_busy || !rx_cond.boot_done)
        |=> !command_ready_flag) else $error("ready during boot or reset");
    chk_recov_entry: assert property (s_run and s_calm and rx_cond.recov_error |=> flg == 3'h6)
        else $error("recoverable error flags");
    chk_pos_follow: assert property (s_run and s_calm and !rx_cond.recov_error
        |=> position_valid_flag == $past(rx_cond.solution_ok)) else $error("position valid lag");
    chk_mark_single: assert property ((mark_event & $past(mark_event)) == 4'h0)
        else $error("mark event longer than one cycle");
    chk_freq_idle: assert property (!$past(freq_output_config_cmd.valid)
        |-> ((fo ^ ~fpol_r) & ~fen_r) == 4'h0) else $error("disabled output not at inactive level");
endmodule

bind rss_status_strobes rss_ss_chk #(.HP_W(HP_W), .MIN_CYC(MIN_CYC)) i_rss_ss_chk (
    .core_clk(core_clk), .rst_n(rst_n), .rx_cond(rx_cond), .freq_output_config_cmd(freq_output_config_cmd),
    .error_flag(error_flag), .command_ready_flag(command_ready_flag), .position_valid_flag(position_valid_flag),
    .mark_event(mark_event), .freq_output_one(freq_output_one), .freq_output_two(freq_output_two),
    .freq_output_three(freq_output_three), .freq_output_four(freq_output_four)
);

// File: tb/rss_host_model.sv
// Host-side model that drives the four event mark pins
`timescale 1ns/1ns
module rss_host_model (
    input  wire logic       core_clk,
    output logic      [3:0] mark_pins
);
    logic [3:0] pol_r;
    initial begin
        pol_r     = 4'h0;
        mark_pins = 4'hf;
    end
////////////////////////////////////////////////////////////
    // Pins rest at the inactive level of the polarity in force
    task automatic set_pol(input logic [3:0] pol);
        @(negedge core_clk);
        pol_r     = pol;
        mark_pins = ~pol;
    endtask
    // Trailing idle gap lets the receiver re-arm before the next pulse
    task automatic pulse(input int ch, input int width);
        @(negedge core_clk);
        mark_pins[ch] = pol_r[ch];
        repeat (width) @(negedge core_clk);
        mark_pins[ch] = ~pol_r[ch];
        repeat (24) @(negedge core_clk);
    endtask
endmodule

// File: tb/receiver_status_strobes_tb.sv
// Self-checking bench for the status flags, mark inputs and frequency outputs
`timescale 1ns/1ns
module receiver_status_strobes_tb;
    logic                      core_clk;
    logic                      rst_n;
    rss_pkg::rss_rx_cond_type  rx_cond;
    rss_pkg::rss_mark_cfg_type mcfg;
    rss_pkg::rss_freq_cfg_type fcfg;
    logic [3:0]                pins;
    logic [3:0]                mark_event;
    logic [3:0]                fo;
    logic [2:0]                flg;
    int                        n_mismatch = 0;
    int                        tests_run = 0;
    int                        cyc = 0;
    int                        ev [4] = '{default: 0};

    rss_host_model i_rss_host_model (.core_clk(core_clk), .mark_pins(pins));
    rss_status_strobes #(.HP_W(24), .MIN_CYC(15)) i_rss_status_strobes (
        .core_clk(core_clk), .rst_n(rst_n), .rx_cond(rx_cond), .mark_input_one(pins[0]),
        .mark_input_two(pins[1]), .mark_input_three(pins[2]), .mark_input_four(pins[3]),
        .mark_input_config_cmd(mcfg), .freq_output_config_cmd(fcfg), .error_flag(flg[2]),
        .command_ready_flag(flg[1]), .position_valid_flag(flg[0]), .mark_event(mark_event),
        .freq_output_one(fo[0]), .freq_output_two(fo[1]), .freq_output_three(fo[2]), .freq_output_four(fo[3])
    );
////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Whole run takes about 2500 cycles, most of them the long mid-run reset
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            summarize();
        end
    end
    always @(negedge core_clk) begin
        foreach (ev[i]) ev[i] += int'(mark_event[i] === 1'b1);
    end
////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Field order: boot, reset busy, recoverable, fatal, restart done, solution
    task automatic cond(input logic [5:0] v, input logic [2:0] exp);
        rx_cond = v;
        step(3);
        chk(flg, exp, "status flags");
    endtask
    task automatic cfg_freq(input int c, input logic en, input logic ah, input int hp);
        fcfg = '{valid: 1'b1, chan: 2'(c), enable: en, active_high: ah, half_period: 24'(hp)};
        step(1);
        fcfg.valid = 1'b0;
        step(1);
    endtask
////////////////////////////////////////////////////////////
    task automatic t_quiet();
        chk(flg, 3'h0, "flags after reset");
        chk(fo, 4'hf, "event outputs after reset");
        chk(mark_event, 4'h0, "mark events after reset");
    endtask
    task automatic t_boot();
        cond(6'h00, 3'h0);
        cond(6'h21, 3'h3);
        cond(6'h20, 3'h2);
    endtask
    task automatic t_recov();
        cond(6'h29, 3'h6);
        cond(6'h21, 3'h3);
    endtask
    task automatic t_busy();
        cond(6'h31, 3'h0);
        cond(6'h21, 3'h3);
    endtask
    task automatic t_fatal();
        cond(6'h29, 3'h6);
        cond(6'h2d, 3'h0);
        cond(6'h00, 3'h0);
        cond(6'h02, 3'h0);
        cond(6'h21, 3'h3);
    endtask
    task automatic t_marks();
        int b;
        for (int ch = 0; ch < 4; ch++) begin
            b = ev[ch];
            i_rss_host_model.pulse(ch, 16);
            i_rss_host_model.pulse(ch, 15);
            chk(ev[ch] - b, 1, "mark events, long then short pulse");
        end
    endtask
    task automatic t_polarity();
        int b;
        i_rss_host_model.set_pol(4'hf);
        mcfg = '{valid: 1'b1, active_high: 4'hf};
        step(1);
        mcfg.valid = 1'b0;
        step(24);
        b = ev[2];
        i_rss_host_model.pulse(2, 16);
        chk(ev[2] - b, 1, "active high mark");
    endtask
    task automatic t_freq();
        int   n;
        logic v;
        for (int ch = 0; ch < 4; ch++) begin
            // Half period zero would exceed the top rate and must be clamped to one
            cfg_freq(ch, 1'b1, 1'b0, ch);
            for (int k = 0; k < 2; k++) begin
                v = fo[ch];
                n = 0;
                while (fo[ch] === v && n < 40) begin
                    step(1);
                    n++;
                end
            end
            chk(n, (ch == 0) ? 1 : ch, "half period");
            cfg_freq(ch, 1'b0, 1'b1, 5);
            step(2);
            chk(fo[ch], 1'b0, "disabled output level");
        end
    endtask
    task automatic t_rerun();
        rst_n = 1'b0;
        // Host-side reset with power up must last over 20 us
        step(2001);
        rst_n = 1'b1;
        t_quiet();
    endtask
////////////////////////////////////////////////////////////
    initial begin
        rst_n   = 1'b0;
        rx_cond = '0;
        mcfg    = '0;
        fcfg    = '0;
        step(5);
        rst_n = 1'b1;
        t_quiet();
        t_boot();
        t_recov();
        t_busy();
        t_fatal();
        t_marks();
        t_polarity();
        t_freq();
        t_rerun();
        summarize();
    end
endmodule
